// >>> design/cipr_edge_detect.sv
`timescale 1ns/1ns
module cipr_edge_detect #(
	parameter int WIDTH = 15
) (
	input  wire logic             clock,   // System clock
	input  wire logic             reset_n, // Async reset
	input  wire logic [WIDTH-1:0] pins,    // Asynchronous request pins
	output logic      [WIDTH-1:0] rise     // One-cycle rising edge pulses
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] level_reg;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			// Level only moves once two late stages agree; filters a metastable glitch
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					level_reg[g] <= 1'b0;
				end else if (s2_reg[g] == s3_reg[g]) begin
					level_reg[g] <= s3_reg[g];
				end
			end
			assign rise[g] = (s2_reg[g] == s3_reg[g]) && s3_reg[g] && !level_reg[g];
		end
	endgenerate
endmodule : cipr_edge_detect

// >>> design/cipr_router.sv
`timescale 1ns/1ns
module cipr_router
	import cipr_pkg::*;
#(
	parameter int N_SRC = CIPR_SOURCES
) (
	input  wire logic                       clock,        // System clock
	input  wire logic                       reset_n,      // Async reset, active low
	input  wire logic [CIPR_GEN_IN-1:0]     general_request_inputs,   // External general pins
	input  wire logic [CIPR_AUX_IN-1:0]     auxiliary_request_inputs, // External auxiliary pins
	input  wire logic [CIPR_INT_SRC-1:0]    internal_req, // Internal peripheral levels
	input  wire logic                       nmi_pin,      // Non-maskable request pin
	input  wire cipr_sel_t [N_SRC-1:0]      route_sel,    // Controller input per source
	input  wire logic                       route_load,   // Load route_sel
	input  wire logic                       int_ack,      // CPU takes presented vector
	output cipr_grant_t                     grant,        // Presented request
	output logic                            nmi_out       // Non-maskable pulse
);
	cipr_sel_t [N_SRC-1:0]            map_reg;
	logic [CIPR_EXT_IN-1:0]           ext_rise;
	logic [CIPR_CTL_INPUTS-1:0]       pend_reg;
	logic [CIPR_CTL_INPUTS-1:0]       set_vec;
	logic [N_SRC-1:0]                 src_evt;
	logic [CIPR_INT_SRC-1:0]          int_prev_reg;
	logic                             nmi_rise;
	logic [4:0]                       best_rank;
	logic [4:0]                       best_input;
	logic                             best_valid;
	logic [4:0]                       rank_of [CIPR_CTL_INPUTS];
	logic                             is_level [CIPR_CTL_INPUTS];
	logic [CIPR_INT_SRC-1:0]          int_rise;
	logic [CIPR_CTL_INPUTS-1:0]       ack_clr;
	cipr_grant_t                      grant_next;

	// Controller groups of eight inputs: master, slave 1, slave 2
	localparam int GRP_SIZE  = 8;
	localparam int S1_FIRST  = GRP_SIZE;
	localparam int S2_FIRST  = 2 * GRP_SIZE;

	localparam int M_TOP_END = 2;
	localparam int M_MID_END = 5;
	localparam int M_MID_OFS = 7;
	localparam int M_LOW_OFS = 14;
	localparam int S1_DROP   = 6;
	localparam int S2_DROP   = 4;

	cipr_edge_detect #(
		.WIDTH(CIPR_EXT_IN + 1)
	) u_edge (
		.clock  (clock),
		.reset_n(reset_n),
		.pins   ({nmi_pin, auxiliary_request_inputs, general_request_inputs}),
		.rise   ({nmi_rise, ext_rise})
	);

	// Internal sources pulse on their rising level
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			int_prev_reg <= '0;
		end else begin
			int_prev_reg <= internal_req;
		end
	end
	// Same-clock levels, so no synchroniser; one pulse per rise
	assign int_rise = internal_req & ~int_prev_reg;
	assign src_evt  = {int_rise, ext_rise};

	function automatic cipr_sel_t [N_SRC-1:0] default_map();
		cipr_sel_t [N_SRC-1:0] m;
		m = '0;
		m[0]  = 5'h01;
		m[1]  = 5'h09;
		m[2]  = 5'h0A;
		m[3]  = 5'h0B;
		m[4]  = 5'h0C;
		m[5]  = 5'h11;
		m[6]  = 5'h12;
		m[7]  = 5'h13;
		m[8]  = 5'h15;
		m[9]  = 5'h16;
		m[10] = 5'h17;
		m[11] = 5'h07;
		m[12] = 5'h06;
		m[13] = 5'h0F;
		m[14] = 5'h0E;
		m[CIPR_SRC_PIT0] = 5'h00;
		m[CIPR_SRC_PIT1] = 5'h14;
		m[CIPR_SRC_PIT2] = 5'h06;
		m[CIPR_SRC_RTC]  = 5'h08;
		m[CIPR_SRC_FPU]  = 5'h0D;
		m[CIPR_SRC_SER0] = 5'h03;
		m[CIPR_SRC_SER1] = 5'h04;
		m[CIPR_SRC_GPT0] = 5'h10;
		m[CIPR_SRC_GPT1] = 5'h0F;
		return m;
	endfunction : default_map

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			map_reg <= default_map();
		end else if (route_load) begin
			map_reg <= route_sel;
		end
	end

	// merge sources onto controller inputs
	// Codes of 24 and above leave a source unrouted; shared inputs merge
	always_comb begin
		set_vec = '0;
		for (int s = 0; s < N_SRC; s++) begin
			if (src_evt[s] && map_reg[s] < 5'(CIPR_CTL_INPUTS)) begin
				set_vec[map_reg[s][4:0]] = 1'b1;
			end
		end
	end

	// rank of each controller input; inputs 0-7 master, 8-15 slave 1, 16-23 slave 2
	generate
		for (genvar i = 0; i < CIPR_CTL_INPUTS; i++) begin : g_rank
			if (i < S1_FIRST) begin : g_m
				assign is_level[i] = (5'(i) != CIPR_CASCADE1) && (5'(i) != CIPR_CASCADE2);
				if (i < M_TOP_END) begin : g_top
					assign rank_of[i] = 5'(i);
				end else if (i < M_MID_END) begin : g_mid
					assign rank_of[i] = 5'(i + M_MID_OFS);
				end else begin : g_low
					assign rank_of[i] = 5'(i + M_LOW_OFS);
				end
			end else if (i < S2_FIRST) begin : g_s1
				assign is_level[i] = 1'b1;
				assign rank_of[i]  = 5'(i - S1_DROP);
			end else begin : g_s2
				assign is_level[i] = 1'b1;
				assign rank_of[i]  = 5'(i - S2_DROP);
			end
		end
	endgenerate

	// lowest-numbered pending level wins
	// Cascade inputs carry only sources routed to them, not slave requests, and never win
	always_comb begin
		best_valid = 1'b0;
		best_rank  = CIPR_UNROUTED;
		best_input = '0;
		for (int i = 0; i < CIPR_CTL_INPUTS; i++) begin
			if (pend_reg[i] && is_level[i] && (!best_valid || rank_of[i] < best_rank)) begin
				best_valid = 1'b1;
				best_rank  = rank_of[i];
				best_input = 5'(i);
			end
		end
	end

	// Pending flags; a new edge wins over the acknowledge clear
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pend_reg <= '0;
		end else begin
			for (int i = 0; i < CIPR_CTL_INPUTS; i++) begin
				if (set_vec[i]) begin
					pend_reg[i] <= 1'b1;
				end else if (ack_clr[i]) begin
					pend_reg[i] <= 1'b0;
				end
			end
		end
	end

	// acknowledge clears the input whose vector the CPU took
	always_comb begin
		ack_clr = '0;
		for (int i = 0; i < CIPR_CTL_INPUTS; i++) begin
			ack_clr[i] = int_ack && grant.valid && (grant.vector[4:0] == 5'(i));
		end
	end

	// vector of the winning input
	// Group is the top two index bits; code 3 cannot occur
	always_comb begin
		grant_next.valid = best_valid;
		grant_next.level = best_rank + 5'h01;
		unique case (best_input[4:3])
			2'h0: begin
				grant_next.vector = CIPR_MASTER_BASE + 8'(best_input[2:0]);
			end
			2'h1: begin
				grant_next.vector = CIPR_SLAVE1_BASE + 8'(best_input[2:0]);
			end
			2'h2: begin
				grant_next.vector = CIPR_SLAVE2_BASE + 8'(best_input[2:0]);
			end
			default: begin
				grant_next.vector = CIPR_MASTER_BASE;
			end
		endcase
	end

	// vector stands for the CPU until it acknowledges
	// A higher request may replace it first; the ack applies to what stands
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			grant <= '0;
		end else if (int_ack && grant.valid) begin
			grant <= '0;
		end else begin
			grant <= grant_next;
		end
	end

	// non-maskable path bypasses levels
	// Pulse only: nothing pends and no acknowledge is needed
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			nmi_out <= 1'b0;
		end else begin
			nmi_out <= nmi_rise;
		end
	end
endmodule : cipr_router

// >>> inc/cipr_pkg.sv
package cipr_pkg;
	localparam int CIPR_LEVELS     = 22;
	localparam int CIPR_GEN_IN     = 11;
	localparam int CIPR_AUX_IN     = 4;
	localparam int CIPR_EXT_IN     = CIPR_GEN_IN + CIPR_AUX_IN;
	localparam int CIPR_INT_SRC    = 9;
	localparam int CIPR_SOURCES    = CIPR_EXT_IN + CIPR_INT_SRC;
	localparam int CIPR_CTL_INPUTS = 24;
	localparam int CIPR_SEL_W      = 5;
	localparam logic [4:0] CIPR_UNROUTED = 5'h1F;
	localparam logic [7:0] CIPR_MASTER_BASE = 8'h40;
	localparam logic [7:0] CIPR_SLAVE1_BASE = 8'h48;
	localparam logic [7:0] CIPR_SLAVE2_BASE = 8'h50;
	localparam logic [4:0] CIPR_CASCADE1 = 5'h02;
	localparam logic [4:0] CIPR_CASCADE2 = 5'h05;
	// Internal source indices, after the 15 external ones
	localparam int CIPR_SRC_PIT0 = 15;
	localparam int CIPR_SRC_PIT1 = 16;
	localparam int CIPR_SRC_PIT2 = 17;
	localparam int CIPR_SRC_RTC  = 18;
	localparam int CIPR_SRC_FPU  = 19;
	localparam int CIPR_SRC_SER0 = 20;
	localparam int CIPR_SRC_SER1 = 21;
	localparam int CIPR_SRC_GPT0 = 22;
	localparam int CIPR_SRC_GPT1 = 23;

	typedef logic [CIPR_SEL_W-1:0] cipr_sel_t;

	typedef struct packed {
		logic       valid;
		logic [4:0] level;
		logic [7:0] vector;
	} cipr_grant_t;
endpackage : cipr_pkg

// >>> verification/cipr_cpu_model.sv
`timescale 1ns/1ns
module cipr_cpu_model
	import cipr_pkg::*;
(
	input  wire logic        clock,   // System clock
	input  wire logic        reset_n, // Async reset
	input  wire cipr_grant_t grant,   // Presented request
	input  wire logic [3:0]  delay,   // Wait before taking
	output logic             int_ack, // Take pulse
	output logic             taken,   // Vector fetched
	output cipr_grant_t      tg       // Fetched request
);
	logic [3:0] cnt_reg;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			int_ack <= 1'b0;
			taken <= 1'b0;
			tg <= '0;
			cnt_reg <= 4'h0;
		end else begin
			taken <= int_ack & grant.valid;
			tg <= grant;
			int_ack <= 1'b0;
			if (grant.valid && !int_ack) begin
				// Slow CPU lets lower requests pile up
				if (cnt_reg == delay) begin
					int_ack <= 1'b1;
					cnt_reg <= 4'h0;
				end else begin
					cnt_reg <= cnt_reg + 4'h1;
				end
			end
		end
	end
endmodule : cipr_cpu_model

// >>> verification/cipr_router_bench.sv
`timescale 1ns/1ns
module cipr_router_bench
	import cipr_pkg::*;
;
	logic             clock = 1'b0;
	logic             reset_n = 1'b0;
	logic [23:0]      src = '0;
	logic             nmi_pin = 1'b0;
	logic             route_load = 1'b0;
	logic [3:0]       delay = 4'h0;
	cipr_sel_t [23:0] rsel = '1;
	logic             int_ack, taken, nmi_out;
	cipr_grant_t      grant, tg;
	int               err_count = 0;
	int               n_compared = 0;
	int               cycles = 0;
	int map [24] = '{1, 9, 10, 11, 12, 17, 18, 19, 21, 22, 23, 7, 6, 15, 14, 0, 20, 6, 8, 13, 3, 4, 16, 15};
	int ord [22] = '{0, 1, 8, 9, 10, 11, 12, 13, 14, 15, 3, 4, 16, 17, 18, 19, 20, 21, 22, 23, 6, 7};
	always #5 clock = ~clock;
	cipr_router dut (.clock(clock), .reset_n(reset_n), .general_request_inputs(src[10:0]),
		.auxiliary_request_inputs(src[14:11]), .internal_req(src[23:15]), .nmi_pin(nmi_pin), .route_sel(rsel),
		.route_load(route_load), .int_ack(int_ack), .grant(grant), .nmi_out(nmi_out));
	cipr_cpu_model cpu (.clock(clock), .reset_n(reset_n), .grant(grant), .delay(delay), .int_ack(int_ack),
		.taken(taken), .tg(tg));
	function automatic logic [4:0] lvl(int i);
		lvl = 5'(i < 2 ? i + 1 : i < 5 ? i + 8 : i < 8 ? i + 15 : i < 16 ? i - 5 : i - 3);
	endfunction : lvl
	task chk(string what, logic [13:0] exp, logic [13:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask : chk
	task take(int i);
		int n;
		n = 0;
		while (taken !== 1'b1 && n < 60) begin
			@(negedge clock);
			n++;
		end
		chk("grant", {1'b1, lvl(i), 8'h40 + 8'(i)}, {taken, tg.level, tg.vector});
		@(negedge clock);
	endtask : take
	task t_each;
		for (int s = 0; s < 24; s++) begin
			src[s] = 1'b1;
			take(map[s]);
			src[s] = 1'b0;
			repeat (6) @(negedge clock);
		end
		$display("t_each done");
	endtask : t_each
	task t_all;
		delay = 4'h4;
		src = '1;
		foreach (ord[k]) take(ord[k]);
		repeat (20) @(negedge clock);
		chk("idle", 14'h0, grant.valid);
		src = '0;
		repeat (8) @(negedge clock);
		$display("t_all done");
	endtask : t_all
	task t_nmi;
		nmi_pin = 1'b1;
		for (int n = 0; n < 12 && nmi_out !== 1'b1; n++) @(negedge clock);
		chk("nmi", 14'h2, {nmi_out, grant.valid});
		nmi_pin = 1'b0;
		repeat (4) @(negedge clock);
		$display("t_nmi done");
	endtask : t_nmi
	task t_route;
		rsel[0] = 5'h17;
		route_load = 1'b1;
		@(negedge clock);
		route_load = 1'b0;
		src[14:0] = '1;
		take(23);
		repeat (20) @(negedge clock);
		chk("unrouted", 14'h0, grant.valid);
		$display("t_route done");
	endtask : t_route
	task t_reset;
		src = '0;
		repeat (6) @(negedge clock);
		reset_n = 1'b0;
		repeat (2) @(negedge clock);
		reset_n = 1'b1;
		@(negedge clock);
		chk("after reset", 14'h0, {grant.valid, nmi_out});
		src[0] = 1'b1;
		take(1);
		src[0] = 1'b0;
		repeat (6) @(negedge clock);
		$display("t_reset done");
	endtask : t_reset
	task end_sim;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim
	// Whole run needs about six hundred cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			end_sim;
		end
	end
	initial begin
		repeat (5) @(negedge clock);
		reset_n = 1'b1;
		@(negedge clock);
		t_each;
		t_all;
		t_nmi;
		t_route;
		t_reset;
		end_sim;
	end
endmodule : cipr_router_bench

// >>> verification/cipr_router_properties.sv
`timescale 1ns/1ns
module cipr_router_properties
	import cipr_pkg::*;
(
	input wire logic             clock,        // System clock
	input wire logic             reset_n,      // Async reset
	input wire logic [CIPR_INT_SRC-1:0] internal_req, // Internal levels
	input wire logic             nmi_pin,      // NMI pin
	input wire logic             route_load,   // Table load
	input wire logic             int_ack,      // CPU take
	input wire cipr_grant_t      grant,        // Presented request
	input wire logic             nmi_out       // NMI pulse
);
	function automatic logic [7:0] vof(logic [4:0] l);
		vof = l < 3 ? 8'h3F + l : l < 11 ? 8'h45 + l : l < 13 ? 8'h38 + l : l < 21 ? 8'h43 + l : 8'h31 + l;
	endfunction : vof
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// Top-input check only holds while the reset map is in force
	logic remapped_reg;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			remapped_reg <= 1'b0;
		end else if (route_load) begin
			remapped_reg <= 1'b1;
		end
	end
	chk_level_range:
	assert property (grant.valid |-> grant.level inside {[5'h01:5'h16]}) else $error("level out of range");
	chk_vector_map:
	assert property (grant.valid |-> grant.vector == vof(grant.level)) else $error("vector not of level");
	chk_no_cascade:
	assert property (grant.valid |-> !(grant.vector inside {8'h42, 8'h45})) else $error("cascade input granted");
	chk_grant_stands:
	assert property (grant.valid && !int_ack |=> grant.valid && grant.level <= $past(grant.level))
		else $error("grant dropped or lowered");
	chk_ack_clears:
	assert property (grant.valid && int_ack |=> !grant.valid) else $error("grant kept after ack");
	chk_top_first:
	assert property ($rose(internal_req[0]) && !grant.valid && !remapped_reg |-> ##[1:3] grant.valid && grant.level == 5'h01)
		else $error("top level not shown");
	chk_nmi_pulse:
	assert property (nmi_out |=> !nmi_out) else $error("nmi pulse too long");
	chk_nmi_follows:
	assert property ($rose(nmi_pin) |-> ##[2:8] nmi_out) else $error("nmi not passed");
endmodule : cipr_router_properties
bind cipr_router cipr_router_properties chk (.clock, .reset_n, .internal_req, .nmi_pin, .route_load, .int_ack, .grant,
	.nmi_out);
